// ---- core/mbp_pkg.sv ----
// Constants and types shared by both ends of the host bus and port pins link
// Assumes one 40 MHz clock and an active-low asynchronous reset on both ends
//
// How it works
// (R1) Address strobe captures address, held for cycle
// (R2) Drive read data only when read and selected
// (R3) Latched address bits feed the logic decoders
// (R4) Low port carries low address/data by host mode
// (R5) High port carries high address/data by host mode
// (R6) Write input is write strobe or read/write level
// (R7) Read input is read, E, strobe or fetch
// (R8) Fetch input marks code accesses or generic input
// (R9) Reset clears ports and macrocells
// (R10) Host holds reset low at power-up
// (R11) Port A pins select one of many functions
// (R12) Port A low nibble push-pull, high nibble selectable
// (R13) Port B pins select I/O, macrocell, input, address
// (R14) Port B low nibble push-pull, high nibble selectable
package mbp_pkg;

  // ****************************************************************
  // Host bus modes
  // ****************************************************************
  typedef enum logic [1:0] {MBP_MUX, MBP_NONMUX, MBP_PAGE, MBP_BURST} mbp_bus_e;
  typedef enum logic [1:0] {MBP_RD_STROBE, MBP_RD_ECLK, MBP_RD_DSTROBE, MBP_RD_FETCH} mbp_rd_e;

  // Port pin functions
  typedef enum logic [2:0]
  {
    MBP_PIN_MCU_IO, MBP_PIN_MCELL, MBP_PIN_LOGIC_IN, MBP_PIN_ADDR_OUT,
    MBP_PIN_ADDR_IN, MBP_PIN_DATA_IN, MBP_PIN_DATA_HADDR, MBP_PIN_PERIPH
  } mbp_pin_e;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int         MBP_W            = 8;
  localparam int         MBP_OD_FIRST_BIT = 4;
  localparam logic [7:0] MBP_RST_BYTE     = 8'h00;
  localparam logic [7:0] MBP_PUSH_PULL    = 8'h0F;

endpackage : mbp_pkg

// ---- core/mbp_if.sv ----
// Pin-level link between the host bus end and the device end
// Assumes both ends share sys_clk_i; pin level is resolved here from enables
`timescale 1ns/100ps
interface mbp_if;
  logic [7:0] low_addr_data_port_host;
  logic [7:0] low_addr_data_port_host_oe;
  logic [7:0] high_addr_data_port_host;
  logic [7:0] high_addr_data_port_host_oe;
  logic [7:0] low_addr_data_port_dev;
  logic [7:0] low_addr_data_port_dev_oe;
  logic [7:0] high_addr_data_port_dev;
  logic [7:0] high_addr_data_port_dev_oe;
  logic [7:0] low_addr_data_port;
  logic [7:0] high_addr_data_port;
  logic       addr_strobe;
  logic       write_control_input;
  logic       read_control_input;
  logic       fetch_control_input;
  logic       reset_low;

  // Wire level: whichever end enables drives, the device end if both do, else pulled high
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      low_addr_data_port[i]  = low_addr_data_port_dev_oe[i] ? low_addr_data_port_dev[i] :
                               low_addr_data_port_host_oe[i] ? low_addr_data_port_host[i] : 1'b1;
      high_addr_data_port[i] = high_addr_data_port_dev_oe[i] ? high_addr_data_port_dev[i] :
                               high_addr_data_port_host_oe[i] ? high_addr_data_port_host[i] : 1'b1;
    end
  end

  modport host (output low_addr_data_port_host, low_addr_data_port_host_oe,
                high_addr_data_port_host, high_addr_data_port_host_oe,
                addr_strobe, write_control_input, read_control_input,
                fetch_control_input, reset_low,
                input low_addr_data_port, high_addr_data_port);
  modport dev  (output low_addr_data_port_dev, low_addr_data_port_dev_oe,
                high_addr_data_port_dev, high_addr_data_port_dev_oe,
                input low_addr_data_port, high_addr_data_port, addr_strobe,
                write_control_input, read_control_input, fetch_control_input, reset_low);
endinterface : mbp_if

// ---- core/mbp_dev.sv ----
// Device end: bus front end, address latch, read drive and ports A and B
// Assumes host controls are synchronous to sys_clk_i; strobes active per mode
`timescale 1ns/100ps
module mbp_dev
(
  input  wire logic               sys_clk_i,
  input  wire logic               resetn_i,
  mbp_if.dev                      bus,
  input  wire mbp_pkg::mbp_bus_e  bus_mode_i,
  input  wire mbp_pkg::mbp_rd_e   read_mode_i,
  input  wire logic               write_is_rw_i,
  input  wire logic               block_sel_i,
  input  wire logic [7:0]         rd_low_i,
  input  wire logic [7:0]         rd_high_i,
  input  wire mbp_pkg::mbp_pin_e  port_a_func_i [8],
  input  wire mbp_pkg::mbp_pin_e  port_b_func_i [8],
  input  wire logic               port_b_bank_sel_i,
  input  wire logic [7:0]         open_drain_a_i,
  input  wire logic [7:0]         open_drain_b_i,
  input  wire logic [7:0]         slew_fast_a_i,
  input  wire logic [7:0]         slew_fast_b_i,
  input  wire logic [7:0]         port_a_out_i,
  input  wire logic [7:0]         port_b_out_i,
  input  wire logic [7:0]         port_a_dir_i,
  input  wire logic [7:0]         port_b_dir_i,
  input  wire logic [7:0]         macrocell_bank_first_i,
  input  wire logic [7:0]         macrocell_bank_second_i,
  input  wire logic [7:0]         port_a_pins_i,
  input  wire logic [7:0]         port_b_pins_i,
  output logic [15:0]             decoder_addr_o,
  output logic                    write_active_o,
  output logic                    read_active_o,
  output logic                    fetch_active_o,
  output logic [7:0]              port_a_pins_o,
  output logic [7:0]              port_a_pins_oe_o,
  output logic [7:0]              port_a_slew_o,
  output logic [7:0]              port_b_pins_o,
  output logic [7:0]              port_b_pins_oe_o,
  output logic [7:0]              port_b_slew_o,
  output logic [7:0]              logic_in_o
);

  // ****************************************************************
  // Address capture
  // ****************************************************************
  logic [15:0] addr;
  logic [15:0] next_addr;
  logic [7:0]  a_out;
  logic [7:0]  next_a_out;
  logic [7:0]  a_oe;
  logic [7:0]  next_a_oe;
  logic [7:0]  b_out;
  logic [7:0]  next_b_out;
  logic [7:0]  b_oe;
  logic [7:0]  next_b_oe;
  logic        rd;
  logic        wr;
  logic [7:0]  next_lin;
  logic [7:0]  od_a;
  logic [7:0]  od_b;

  // Open-drain only allowed on the upper nibble; lower stays push-pull
  function automatic logic [7:0] od_mask(input logic [7:0] req);
    od_mask = req & ~mbp_pkg::MBP_PUSH_PULL; // R12 R14
  endfunction : od_mask

  // Host address follows the strobe; held once it drops for the data phase
  always_comb
  begin
    next_addr = addr;
    if (bus.addr_strobe)
    begin
      unique case (bus_mode_i)
        mbp_pkg::MBP_BURST: next_addr = {bus.high_addr_data_port, bus.low_addr_data_port} << 4; // R4 R5
        default:            next_addr = {bus.high_addr_data_port, bus.low_addr_data_port}; // R4 R5
      endcase // R1
    end
  end

  // Read strobe decoded per host style; E clock is active high
  always_comb
  begin
    unique case (read_mode_i)
      mbp_pkg::MBP_RD_ECLK: rd = bus.read_control_input && bus.write_control_input; // R7
      default:              rd = !bus.read_control_input; // R7
    endcase
    wr = write_is_rw_i ? (!bus.write_control_input && !rd) : !bus.write_control_input; // R6
  end

  // ****************************************************************
  // Port pin drive
  // ****************************************************************
  always_comb
  begin
    od_a = od_mask(open_drain_a_i); // R12
    od_b = od_mask(open_drain_b_i); // R14
    for (int i = 0; i < 8; i++)
    begin
      next_a_out[i] = 1'b0;
      next_a_oe[i]  = 1'b0;
      next_b_out[i] = 1'b0;
      next_b_oe[i]  = 1'b0;
      unique case (port_a_func_i[i])
        mbp_pkg::MBP_PIN_MCU_IO:     {next_a_oe[i], next_a_out[i]} = {port_a_dir_i[i], port_a_out_i[i]};
        mbp_pkg::MBP_PIN_MCELL:      {next_a_oe[i], next_a_out[i]} = {1'b1, macrocell_bank_first_i[i]};
        mbp_pkg::MBP_PIN_ADDR_OUT:   {next_a_oe[i], next_a_out[i]} = {1'b1, addr[i]};
        mbp_pkg::MBP_PIN_PERIPH:     {next_a_oe[i], next_a_out[i]} = {rd && block_sel_i, rd_low_i[i]};
        mbp_pkg::MBP_PIN_DATA_HADDR: {next_a_oe[i], next_a_out[i]} = {rd && block_sel_i, rd_low_i[i]};
        default:                     {next_a_oe[i], next_a_out[i]} = 2'b00; // R11
      endcase
      unique case (port_b_func_i[i])
        mbp_pkg::MBP_PIN_MCU_IO:   {next_b_oe[i], next_b_out[i]} = {port_b_dir_i[i], port_b_out_i[i]};
        mbp_pkg::MBP_PIN_MCELL:    {next_b_oe[i], next_b_out[i]} = {1'b1, port_b_bank_sel_i ?
                                     macrocell_bank_second_i[i] : macrocell_bank_first_i[i]};
        mbp_pkg::MBP_PIN_ADDR_OUT: {next_b_oe[i], next_b_out[i]} = {1'b1, addr[i + 8]};
        default:                   {next_b_oe[i], next_b_out[i]} = 2'b00; // R13
      endcase
      // Open-drain pin only drives low; a high releases the pin
      if (od_a[i] && next_a_out[i])
        next_a_oe[i] = 1'b0; // R12
      if (od_b[i] && next_b_out[i])
        next_b_oe[i] = 1'b0; // R14
    end
    next_lin = {port_b_pins_i[3:0], port_a_pins_i[3:0]};
  end

  // All state cleared by reset: ports, latch and macrocell-facing outputs
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      addr                         <= 16'h0000; // R9
      a_out                        <= mbp_pkg::MBP_RST_BYTE;
      a_oe                         <= mbp_pkg::MBP_RST_BYTE;
      b_out                        <= mbp_pkg::MBP_RST_BYTE;
      b_oe                         <= mbp_pkg::MBP_RST_BYTE;
      bus.low_addr_data_port_dev     <= mbp_pkg::MBP_RST_BYTE;
      bus.low_addr_data_port_dev_oe  <= mbp_pkg::MBP_RST_BYTE;
      bus.high_addr_data_port_dev    <= mbp_pkg::MBP_RST_BYTE;
      bus.high_addr_data_port_dev_oe <= mbp_pkg::MBP_RST_BYTE;
      decoder_addr_o               <= 16'h0000;
      write_active_o               <= 1'b0;
      read_active_o                <= 1'b0;
      fetch_active_o               <= 1'b0;
      port_a_slew_o                <= mbp_pkg::MBP_RST_BYTE;
      port_b_slew_o                <= mbp_pkg::MBP_RST_BYTE;
      logic_in_o                   <= mbp_pkg::MBP_RST_BYTE;
    end
    else
    begin
      addr                         <= next_addr; // R1
      a_out                        <= next_a_out;
      a_oe                         <= next_a_oe;
      b_out                        <= next_b_out;
      b_oe                         <= next_b_oe;
      bus.low_addr_data_port_dev     <= rd_low_i;
      bus.low_addr_data_port_dev_oe  <= {8{rd && block_sel_i}}; // R2
      bus.high_addr_data_port_dev    <= rd_high_i;
      bus.high_addr_data_port_dev_oe <= {8{rd && block_sel_i}}; // R2
      decoder_addr_o               <= next_addr; // R3
      write_active_o               <= wr; // R6
      read_active_o                <= rd; // R7
      fetch_active_o               <= !bus.fetch_control_input; // R8
      port_a_slew_o                <= slew_fast_a_i & mbp_pkg::MBP_PUSH_PULL; // R12
      port_b_slew_o                <= slew_fast_b_i & mbp_pkg::MBP_PUSH_PULL; // R14
      logic_in_o                   <= next_lin;
    end
  end

  assign port_a_pins_o    = a_out;
  assign port_a_pins_oe_o = a_oe;
  assign port_b_pins_o    = b_out;
  assign port_b_pins_oe_o = b_oe;

endmodule : mbp_dev

// ---- core/mbp_host.sv ----
// Host end: runs one multiplexed bus cycle per request on the link
// Assumes device samples strobes on sys_clk_i; reset pin follows resetn_i
`timescale 1ns/100ps
module mbp_host
(
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  mbp_if.host              bus,
  input  wire logic        req_i,
  input  wire logic        req_write_i,
  input  wire logic        req_fetch_i,
  input  wire logic [15:0] req_addr_i,
  input  wire logic [15:0] req_wdata_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [15:0]      rdata_o
);

  typedef enum logic [1:0] {MBP_IDLE, MBP_ADDR, MBP_DATA, MBP_END} mbp_hst_e;
  mbp_hst_e    state;
  mbp_hst_e    next_state;
  logic        wr;
  logic        next_wr;

  // One phase per cycle: address with strobe, data with strobe, finish
  always_comb
  begin
    next_state = state;
    next_wr    = wr;
    unique case (state)
      MBP_IDLE:
        if (req_i)
        begin
          next_state = MBP_ADDR;
          next_wr    = req_write_i;
        end
      MBP_ADDR: next_state = MBP_DATA;
      MBP_DATA: next_state = MBP_END;
      MBP_END:  next_state = MBP_IDLE;
    endcase
  end

  // Pins registered so device sees clean edges; reset pin held low in reset
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state                        <= MBP_IDLE;
      wr                           <= 1'b0;
      bus.reset_low                <= 1'b0; // R10
      bus.addr_strobe              <= 1'b0;
      bus.write_control_input      <= 1'b1;
      bus.read_control_input       <= 1'b1;
      bus.fetch_control_input      <= 1'b1;
      bus.low_addr_data_port_host     <= mbp_pkg::MBP_RST_BYTE;
      bus.low_addr_data_port_host_oe  <= mbp_pkg::MBP_RST_BYTE;
      bus.high_addr_data_port_host    <= mbp_pkg::MBP_RST_BYTE;
      bus.high_addr_data_port_host_oe <= mbp_pkg::MBP_RST_BYTE;
      busy_o                       <= 1'b0;
      done_o                       <= 1'b0;
      rdata_o                      <= 16'h0000;
    end
    else
    begin
      state                        <= next_state;
      wr                           <= next_wr;
      bus.reset_low                <= 1'b1;
      bus.addr_strobe              <= (next_state == MBP_ADDR); // R1
      bus.write_control_input      <= !(next_state == MBP_DATA && next_wr); // R6
      bus.read_control_input       <= !(next_state == MBP_DATA && !next_wr); // R7
      bus.fetch_control_input      <= !(next_state != MBP_IDLE && req_fetch_i); // R8
      bus.low_addr_data_port_host     <= (next_state == MBP_ADDR) ? req_addr_i[7:0]
                                                                   : req_wdata_i[7:0]; // R4
      bus.high_addr_data_port_host    <= (next_state == MBP_ADDR) ? req_addr_i[15:8]
                                                                   : req_wdata_i[15:8]; // R5
      bus.low_addr_data_port_host_oe  <= {8{next_state == MBP_ADDR || (next_state == MBP_DATA && next_wr)}};
      bus.high_addr_data_port_host_oe <= {8{next_state == MBP_ADDR || (next_state == MBP_DATA && next_wr)}};
      busy_o                       <= (next_state != MBP_IDLE);
      done_o                       <= (state == MBP_END);
      if (state == MBP_END && !wr)
        rdata_o <= {bus.high_addr_data_port, bus.low_addr_data_port};
    end
  end

endmodule : mbp_host

// ---- sim/mbp_monitor.sv ----
// Checker for the pin-level link between the host end and the device end
// Assumes it sits beside the interface and gets its signals by name
`timescale 1ns/100ps
module mbp_monitor
(
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       addr_strobe,
  input  wire logic       write_control_input,
  input  wire logic       read_control_input,
  input  wire logic       reset_low,
  input  wire logic [7:0] low_addr_data_port_dev_oe,
  input  wire logic [7:0] high_addr_data_port_dev_oe,
  input  wire logic [7:0] low_addr_data_port_host_oe
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // ****************************************************************
  // Bus cycle steps
  // ****************************************************************
  sequence s_idle;
    read_control_input && write_control_input;
  endsequence
  sequence s_cmd;
    !read_control_input || !write_control_input;
  endsequence

  a_strobe_one_cycle: assert property (addr_strobe |=> !addr_strobe)
    else $error("address strobe held longer than one cycle");
  a_strobe_then_cmd: assert property (addr_strobe |-> s_idle ##1 s_cmd ##1 s_idle)
    else $error("bus cycle steps out of order");
  a_read_one_cycle: assert property ($fell(read_control_input) |=> read_control_input)
    else $error("read phase longer than one cycle");
  // Device drive must trace back to a read one cycle earlier
  a_drive_needs_read: assert property ((low_addr_data_port_dev_oe != 8'h00)
    |-> $past(read_control_input) == 1'b0)
    else $error("device drives low port without a read");
  a_write_no_drive: assert property (!write_control_input
    |-> (low_addr_data_port_dev_oe | high_addr_data_port_dev_oe) == 8'h00)
    else $error("device drives during a write");
  a_idle_released: assert property (read_control_input && $past(read_control_input)
    |-> (low_addr_data_port_dev_oe | high_addr_data_port_dev_oe) == 8'h00)
    else $error("device still drives after read ended");
  a_no_contention: assert property ((low_addr_data_port_dev_oe & low_addr_data_port_host_oe)
    == 8'h00)
    else $error("both ends drive the low port");
  a_high_whole_byte: assert property (high_addr_data_port_dev_oe == 8'h00
    || high_addr_data_port_dev_oe == 8'hFF)
    else $error("high port driven in part");
  a_reset_pin_high: assert property ($past(resetn_i) |-> reset_low)
    else $error("reset pin low outside reset");
  c_read_cycle: cover property (addr_strobe ##1 !read_control_input);
endmodule : mbp_monitor

// ---- sim/mbp_tb.sv ----
// Self-checking bench: host end and device end joined by the link interface
// Assumes a 40 MHz clock; inputs change on the falling edge only
`timescale 1ns/100ps
module mbp_tb;
  logic sys_clk_i, resetn_i, req_i, req_write_i, busy_o, done_o, wrs, bsel, bank;
  logic [15:0] req_addr_i, req_wdata_i, rdata_o, dec_addr;
  logic [7:0]  rdl, rdh, oda, odb, sla, slb, oa, ob, da, db, mc1, mc2, pia, pib;
  logic [7:0]  pao, paoe, pas, pbo, pboe, pbs, lin;
  logic wa, ra, fa_o, fch, seen_wr, seen_rd, seen_fetch, seen_busy;
  logic [15:0] lat_addr;
  logic [15:0] exp_q [$];
  mbp_pkg::mbp_bus_e bmode;
  mbp_pkg::mbp_pin_e fa [8];
  mbp_pkg::mbp_pin_e fb [8];
  int failures, tests_run, n;
  mbp_if link ();

  mbp_host mbp_host_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus(link.host),
    .req_i(req_i), .req_write_i(req_write_i), .req_fetch_i(fch), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o));
  mbp_dev mbp_dev_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus(link.dev),
    .bus_mode_i(bmode), .read_mode_i(mbp_pkg::MBP_RD_STROBE),
    .write_is_rw_i(wrs), .block_sel_i(bsel), .rd_low_i(rdl), .rd_high_i(rdh),
    .port_a_func_i(fa), .port_b_func_i(fb), .port_b_bank_sel_i(bank),
    .open_drain_a_i(oda), .open_drain_b_i(odb), .slew_fast_a_i(sla), .slew_fast_b_i(slb),
    .port_a_out_i(oa), .port_b_out_i(ob), .port_a_dir_i(da), .port_b_dir_i(db),
    .macrocell_bank_first_i(mc1), .macrocell_bank_second_i(mc2),
    .port_a_pins_i(pia), .port_b_pins_i(pib), .decoder_addr_o(dec_addr),
    .write_active_o(wa), .read_active_o(ra), .fetch_active_o(fa_o),
    .port_a_pins_o(pao), .port_a_pins_oe_o(paoe), .port_a_slew_o(pas),
    .port_b_pins_o(pbo), .port_b_pins_oe_o(pboe), .port_b_slew_o(pbs), .logic_in_o(lin));
  mbp_monitor mbp_monitor_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .addr_strobe(link.addr_strobe), .write_control_input(link.write_control_input),
    .read_control_input(link.read_control_input), .reset_low(link.reset_low),
    .low_addr_data_port_dev_oe(link.low_addr_data_port_dev_oe),
    .high_addr_data_port_dev_oe(link.high_addr_data_port_dev_oe),
    .low_addr_data_port_host_oe(link.low_addr_data_port_host_oe));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // ****************************************************************
  // Compare and closing tasks
  // ****************************************************************
  task automatic check_bus(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_bus
  task automatic check_pin(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_bus(what, {8'h00, exp}, {8'h00, got});
  endtask : check_pin
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // One bus cycle; waits for done under a bound so a hang cannot stall the run
  task automatic bus_cycle(input logic wr, input logic [15:0] addr, input logic [15:0] wd);
    req_i = 1'b1; req_write_i = wr; req_addr_i = addr; req_wdata_i = wd;
    {seen_wr, seen_rd, seen_fetch, seen_busy} = 4'h0;
    @(negedge sys_clk_i);
    req_i = 1'b0;
    // Collect the level outputs seen during the cycle; X propagates into the compare
    for (n = 0; n < 20 && done_o !== 1'b1; n++)
    begin
      @(negedge sys_clk_i);
      seen_wr    = seen_wr | wa;
      seen_rd    = seen_rd | ra;
      seen_fetch = seen_fetch | fa_o;
      seen_busy  = seen_busy | busy_o;
    end
    if (n == 20)
    begin
      failures++;
      $display("[FAIL] done expected 1 seen %b", done_o);
      close_out();
    end
    @(negedge sys_clk_i);
  endtask : bus_cycle

  // Port model: open-drain only on the high nibble, fast slew only on the low one
  task automatic check_ports;
    check_pin("port_a_oe", da & ~(oda & 8'hF0 & oa), paoe);
    check_pin("port_b_oe", db & ~(odb & 8'hF0 & ob), pboe);
    check_pin("port_a_slew", sla & 8'h0F, pas);
    check_pin("port_b_slew", slb & 8'h0F, pbs);
  endtask : check_ports

  initial
  begin
    failures = 0; tests_run = 0; resetn_i = 1'b0; req_i = 1'b0; req_write_i = 1'b0;
    req_addr_i = 16'h0000; req_wdata_i = 16'h0000; wrs = 1'b0; bsel = 1'b0; bank = 1'b0;
    fch = 1'b0; bmode = mbp_pkg::MBP_MUX; lat_addr = 16'h0000;
    {rdl, rdh, oda, odb, sla, slb, oa, ob, da, db, mc1, mc2, pia, pib} = '0;
    foreach (fa[i]) begin fa[i] = mbp_pkg::MBP_PIN_MCU_IO; fb[i] = mbp_pkg::MBP_PIN_MCU_IO; end
    void'($urandom(25483));
    repeat (10) @(negedge sys_clk_i);
    check_bus("reset_addr", 16'h0000, dec_addr);
    check_pin("reset_port_a", mbp_pkg::MBP_RST_BYTE, paoe);
    resetn_i = 1'b1;
    @(negedge sys_clk_i);
    // Writes and reads with random addresses; block select alternates
    for (int k = 0; k < 8; k++)
    begin
      rdl = 8'($urandom); rdh = 8'($urandom); bsel = k[0]; wrs = k[1]; fch = k[2] ^ k[0];
      bmode = mbp_pkg::mbp_bus_e'(k[1:0]);
      if (!k[2])
        exp_q.push_back(bsel ? {rdh, rdl} : 16'hFFFF);
      bus_cycle(k[2], 16'($urandom), 16'($urandom));
      // Burst hosts put address bits four and up on the pins
      lat_addr = (bmode == mbp_pkg::MBP_BURST) ? {req_addr_i[11:0], 4'h0} : req_addr_i;
      check_bus("decoder_addr", lat_addr, dec_addr);
      check_pin("cycle_flags", {4'h0, k[2], !k[2], fch, 1'b1},
                {4'h0, seen_wr, seen_rd, seen_fetch, seen_busy});
      if (!k[2])
        check_bus("read_data", exp_q.pop_front(), rdata_o);
    end
    $display("bus test done");
    // Random port settings in MCU I/O mode, then macrocell and logic input modes
    for (int k = 0; k < 16; k++)
    begin
      {oda, odb, sla, slb} = $urandom;
      {oa, ob, da, db} = $urandom;
      repeat (2) @(negedge sys_clk_i);
      check_ports();
      check_pin("port_a_out", oa, pao);
      check_pin("port_b_out", ob, pbo);
    end
    foreach (fa[i]) begin fa[i] = mbp_pkg::MBP_PIN_MCELL; fb[i] = mbp_pkg::MBP_PIN_MCELL; end
    for (int k = 0; k < 4; k++)
    begin
      {mc1, mc2} = 16'($urandom); bank = k[0];
      repeat (2) @(negedge sys_clk_i);
      check_pin("port_a_mcell", mc1, pao);
      check_pin("port_b_mcell", bank ? mc2 : mc1, pbo);
    end
    foreach (fa[i]) begin fa[i] = mbp_pkg::MBP_PIN_LOGIC_IN; fb[i] = mbp_pkg::MBP_PIN_LOGIC_IN; end
    {pia, pib} = 16'($urandom);
    repeat (2) @(negedge sys_clk_i);
    check_pin("logic_in", {pib[3:0], pia[3:0]}, lin);
    // Latched address out on both ports; push-pull so every pin drives
    {oda, odb} = 16'h0000;
    foreach (fa[i]) begin fa[i] = mbp_pkg::MBP_PIN_ADDR_OUT; fb[i] = mbp_pkg::MBP_PIN_ADDR_OUT; end
    repeat (2) @(negedge sys_clk_i);
    check_bus("addr_out", lat_addr, {pbo, pao});
    check_bus("addr_out_oe", 16'hFFFF, {pboe, paoe});
    $display("port test done");
    // Second reset in mid-run clears latch and ports, then a read must work again
    resetn_i = 1'b0;
    @(negedge sys_clk_i);
    check_bus("rereset_addr", 16'h0000, dec_addr);
    check_bus("rereset_ports", 16'h0000, {pboe, paoe});
    resetn_i = 1'b1; bmode = mbp_pkg::MBP_MUX; fch = 1'b0; bsel = 1'b1;
    @(negedge sys_clk_i);
    exp_q.push_back({rdh, rdl});
    bus_cycle(1'b0, 16'($urandom), 16'h0000);
    check_bus("after_reset_addr", req_addr_i, dec_addr);
    check_bus("after_reset_data", exp_q.pop_front(), rdata_o);
    $display("reset test done");
    close_out();
  end
endmodule : mbp_tb
